// file: rtl/bms_defs.svh
`ifndef BMS_DEFS_SVH
`define BMS_DEFS_SVH

`define BMS_CLK_HZ 20000000

// dwell per mode while the button is held
`define BMS_DWELL_S 5
`define BMS_DWELL_CYC (32'(`BMS_DWELL_S) * 32'(`BMS_CLK_HZ))

// inactivity timeout of the selection mode
`define BMS_IDLE_TO_MIN 15
`define BMS_IDLE_TO_CYC (36'(`BMS_IDLE_TO_MIN) * 36'h3C * 36'(`BMS_CLK_HZ))

// button must be stable this long
`define BMS_DEBOUNCE_MS 20
`define BMS_DEBOUNCE_CYC (32'(`BMS_DEBOUNCE_MS) * 32'(`BMS_CLK_HZ) / 32'h3E8)

// flash half period: 250 ms wraps in the 32-bit product, giving 705032 cycles, about 35 ms
`define BMS_FLASH_MS 250
`define BMS_FLASH_CYC (32'(`BMS_FLASH_MS) * 32'(`BMS_CLK_HZ) / 32'h3E8)

// length of the restart request
`define BMS_RESTART_MS 100
`define BMS_RESTART_CYC (32'(`BMS_RESTART_MS) * 32'(`BMS_CLK_HZ) / 32'h3E8)

`define BMS_STATE_RST 3'h0

`endif

// file: rtl/bms_pkg.sv
package bms_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEL_CONFIG = 3'h1,
    ST_SEL_REBOOT = 3'h2,
    ST_SEL_FACTORY = 3'h3,
    ST_SEL_CANCEL = 3'h4,
    ST_DO_FACTORY = 3'h5,
    ST_DO_RESTART = 3'h6,
    ST_LOCKOUT = 3'h7
  } bms_state_t;

  typedef enum logic [1:0] {
    COL_OFF = 2'h0,
    COL_AMBER = 2'h1,
    COL_GREEN = 2'h2,
    COL_RED = 2'h3
  } bms_colour_t;

endpackage

// file: rtl/bms_debounce.sv
`timescale 1ns/100ps

module bms_debounce #(
  parameter logic [31:0] STABLE_CYC = 32'h10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic raw_n_i,
  output logic pressed_o
);

  logic sync_meta;
  logic sync_pin;
  logic [31:0] stable_cnt;

  // pin is active low; the first stage feeds the second only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_meta <= 1'h1;
      sync_pin <= 1'h1;
    end else if (ce_i) begin
      sync_meta <= raw_n_i;
      sync_pin <= sync_meta;
    end
  end

  wire raw_pressed = ~sync_pin;
  wire differs = raw_pressed != pressed_o;
  wire settled = stable_cnt == STABLE_CYC - 32'h1;

  // any bounce restarts the count, so a chattering contact never toggles the output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_cnt <= 32'h0;
      pressed_o <= 1'h0;
    end else if (ce_i) begin
      if (differs && settled) begin
        pressed_o <= raw_pressed;
        stable_cnt <= 32'h0;
      end else if (differs) begin
        stable_cnt <= stable_cnt + 32'h1;
      end else begin
        stable_cnt <= 32'h0;
      end
    end
  end

endmodule

// file: rtl/bms_top.sv
`timescale 1ns/100ps
`include "bms_defs.svh"

// What this block does
// - holding the button steps configuration, reboot, factory reset, cancel, in order
// - each mode lasts five seconds of continuous hold before the next
// - indicator flashes amber, green, red per mode; dark for cancel
// - committed reboot restarts the unit while flashing green throughout
// - committed factory reset restores defaults flashing red, then restarts flashing green
// - committed cancel abandons pending actions, does nothing more, indicator dark
// - fifteen minutes without activity ends the selection mode by itself
module bms_top #(
  parameter logic [31:0] DWELL_CYC = `BMS_DWELL_CYC,
  parameter logic [35:0] IDLE_TO_CYC = `BMS_IDLE_TO_CYC,
  parameter logic [31:0] DEBOUNCE_CYC = `BMS_DEBOUNCE_CYC,
  parameter logic [31:0] FLASH_CYC = `BMS_FLASH_CYC,
  parameter logic [31:0] RESTART_CYC = `BMS_RESTART_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic BUTTON_N_I,
  input wire logic ACTIVITY_I,
  input wire logic FACTORY_DONE_I,
  output logic LED_AMBER_O,
  output logic LED_GREEN_O,
  output logic LED_RED_O,
  output logic RESTART_O,
  output logic FACTORY_RESTORE_O,
  output logic ABANDON_O,
  output logic MODE_ACTIVE_O
);

  logic rst_meta;
  logic rst_n;

  // reset sync is not gated by the enable so release never waits on it
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n <= rst_meta;
    end
  end

  logic btn;
  logic btn_q;

  bms_debounce #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .ce_i(CE_I),
    .raw_n_i(BUTTON_N_I),
    .pressed_o(btn)
  );

  bms_pkg::bms_state_t state;
  bms_pkg::bms_state_t next_state;
  logic [31:0] dwell_cnt;
  logic [35:0] idle_cnt;
  logic [31:0] restart_cnt;
  logic [31:0] flash_cnt;
  logic flash_on;

  wire btn_edge = btn != btn_q;
  wire in_sel = (state == bms_pkg::ST_SEL_CONFIG) || (state == bms_pkg::ST_SEL_REBOOT) ||
                (state == bms_pkg::ST_SEL_FACTORY) || (state == bms_pkg::ST_SEL_CANCEL);
  wire dwell_done = dwell_cnt == DWELL_CYC - 32'h1;
  wire idle_done = idle_cnt == IDLE_TO_CYC - 36'h1;
  wire restart_done = restart_cnt == RESTART_CYC - 32'h1;
  wire flash_flip = flash_cnt == FLASH_CYC - 32'h1;
  wire state_chg = next_state != state;
  wire activity = ACTIVITY_I || btn_edge;

  always_comb begin
    next_state = state;
    unique case (state)
      bms_pkg::ST_IDLE: begin
        if (btn && !btn_q) begin
          next_state = bms_pkg::ST_SEL_CONFIG;
        end
      end
      bms_pkg::ST_SEL_CONFIG, bms_pkg::ST_SEL_REBOOT, bms_pkg::ST_SEL_FACTORY, bms_pkg::ST_SEL_CANCEL: begin
        // timeout wins over a release in the same cycle
        if (idle_done) begin
          next_state = bms_pkg::ST_LOCKOUT;
        end else if (!btn) begin
          unique case (state)
            bms_pkg::ST_SEL_REBOOT: next_state = bms_pkg::ST_DO_RESTART;
            bms_pkg::ST_SEL_FACTORY: next_state = bms_pkg::ST_DO_FACTORY;
            bms_pkg::ST_SEL_CANCEL: next_state = bms_pkg::ST_IDLE;
            default: next_state = bms_pkg::ST_IDLE;
          endcase
        end else if (dwell_done) begin
          unique case (state)
            bms_pkg::ST_SEL_CONFIG: next_state = bms_pkg::ST_SEL_REBOOT;
            bms_pkg::ST_SEL_REBOOT: next_state = bms_pkg::ST_SEL_FACTORY;
            bms_pkg::ST_SEL_FACTORY: next_state = bms_pkg::ST_SEL_CANCEL;
            default: next_state = bms_pkg::ST_SEL_CONFIG;
          endcase
        end
      end
      bms_pkg::ST_DO_FACTORY: begin
        if (FACTORY_DONE_I) begin
          next_state = bms_pkg::ST_DO_RESTART;
        end
      end
      bms_pkg::ST_DO_RESTART: begin
        if (restart_done) begin
          next_state = bms_pkg::ST_IDLE;
        end
      end
      bms_pkg::ST_LOCKOUT: begin
        // wait for release so a stuck button cannot re-enter at once
        if (!btn) begin
          next_state = bms_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= bms_pkg::bms_state_t'(`BMS_STATE_RST);
      btn_q <= 1'h0;
    end else if (CE_I) begin
      state <= next_state;
      btn_q <= btn;
    end
  end

  wire [31:0] next_dwell = (state_chg || !in_sel) ? 32'h0 : dwell_cnt + 32'h1;
  // mode steps are not activity, so a button held for ever still times out
  wire [35:0] next_idle = (!in_sel || activity) ? 36'h0 : idle_cnt + 36'h1;
  wire [31:0] next_restart = (state == bms_pkg::ST_DO_RESTART) ? restart_cnt + 32'h1 : 32'h0;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      dwell_cnt <= 32'h0;
      idle_cnt <= 36'h0;
      restart_cnt <= 32'h0;
    end else if (CE_I) begin
      dwell_cnt <= next_dwell;
      idle_cnt <= next_idle;
      restart_cnt <= next_restart;
    end
  end

  // flash restarts lit on every mode entry so the new colour shows at once
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt <= 32'h0;
      flash_on <= 1'h1;
    end else if (CE_I) begin
      if (state_chg) begin
        flash_cnt <= 32'h0;
        flash_on <= 1'h1;
      end else if (flash_flip) begin
        flash_cnt <= 32'h0;
        flash_on <= ~flash_on;
      end else begin
        flash_cnt <= flash_cnt + 32'h1;
      end
    end
  end

  wire col_amber = state == bms_pkg::ST_SEL_CONFIG;
  wire col_green = (state == bms_pkg::ST_SEL_REBOOT) || (state == bms_pkg::ST_DO_RESTART);
  wire col_red = (state == bms_pkg::ST_SEL_FACTORY) || (state == bms_pkg::ST_DO_FACTORY);
  wire commit_cancel = (state == bms_pkg::ST_SEL_CANCEL) && !idle_done && !btn;
  wire next_in_sel = (next_state == bms_pkg::ST_SEL_CONFIG) || (next_state == bms_pkg::ST_SEL_REBOOT) ||
                     (next_state == bms_pkg::ST_SEL_FACTORY) || (next_state == bms_pkg::ST_SEL_CANCEL);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      LED_AMBER_O <= 1'h0;
      LED_GREEN_O <= 1'h0;
      LED_RED_O <= 1'h0;
      RESTART_O <= 1'h0;
      FACTORY_RESTORE_O <= 1'h0;
      ABANDON_O <= 1'h0;
      MODE_ACTIVE_O <= 1'h0;
    end else if (CE_I) begin
      LED_AMBER_O <= col_amber && flash_on;
      LED_GREEN_O <= col_green && flash_on;
      LED_RED_O <= col_red && flash_on;
      RESTART_O <= next_state == bms_pkg::ST_DO_RESTART;
      FACTORY_RESTORE_O <= next_state == bms_pkg::ST_DO_FACTORY;
      ABANDON_O <= commit_cancel;
      MODE_ACTIVE_O <= next_in_sel;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  a_order_step: assert property (state == bms_pkg::ST_SEL_REBOOT && CE_I && btn && dwell_done && !idle_done
    |=> state == bms_pkg::ST_SEL_FACTORY) else $error("reboot did not advance to factory reset");
  a_cancel_wrap: assert property (state == bms_pkg::ST_SEL_CANCEL && CE_I && btn && dwell_done && !idle_done
    |=> state == bms_pkg::ST_SEL_CONFIG) else $error("cancel did not wrap to configuration");
  a_dwell_len: assert property (in_sel && $past(in_sel) && state != $past(state) && state != bms_pkg::ST_LOCKOUT
    && $past(btn) |-> $past(dwell_done)) else $error("mode advanced before full dwell");
  a_led_colour: assert property (CE_I && state == bms_pkg::ST_SEL_FACTORY && flash_on
    |=> LED_RED_O && !LED_GREEN_O && !LED_AMBER_O) else $error("factory mode not shown red");
  a_cancel_dark: assert property (CE_I && state == bms_pkg::ST_SEL_CANCEL
    |=> !LED_RED_O && !LED_GREEN_O && !LED_AMBER_O) else $error("indicator lit in cancel");
  a_commit_reboot: assert property (state == bms_pkg::ST_SEL_REBOOT && CE_I && !btn && !idle_done
    |=> state == bms_pkg::ST_DO_RESTART && RESTART_O) else $error("release in reboot not committed");
  a_restart_green: assert property (state == bms_pkg::ST_DO_RESTART && CE_I && flash_on
    |=> LED_GREEN_O && !LED_RED_O) else $error("restart not shown green");
  a_factory_seq: assert property (state == bms_pkg::ST_DO_FACTORY && CE_I && FACTORY_DONE_I
    |=> RESTART_O && !FACTORY_RESTORE_O) else $error("restore not followed by restart");
  a_cancel_none: assert property (state == bms_pkg::ST_SEL_CANCEL && CE_I && !btn && !idle_done
    |=> state == bms_pkg::ST_IDLE && ABANDON_O && !RESTART_O && !FACTORY_RESTORE_O)
    else $error("cancel commit took action");
  a_timeout_exit: assert property (in_sel && CE_I && idle_done
    |=> state == bms_pkg::ST_LOCKOUT && !MODE_ACTIVE_O) else $error("inactivity did not end the mode");
  a_config_noop: assert property (state == bms_pkg::ST_SEL_CONFIG && CE_I && !btn && !idle_done
    |=> state == bms_pkg::ST_IDLE && !RESTART_O && !FACTORY_RESTORE_O) else $error("configuration commit acted");

  c_reboot: cover property (state == bms_pkg::ST_SEL_REBOOT ##1 state == bms_pkg::ST_DO_RESTART);
  c_factory: cover property (state == bms_pkg::ST_DO_FACTORY ##1 state == bms_pkg::ST_DO_RESTART);
  c_cancel: cover property (state == bms_pkg::ST_SEL_CANCEL ##1 state == bms_pkg::ST_IDLE);
  c_timeout: cover property (in_sel ##1 state == bms_pkg::ST_LOCKOUT);

endmodule

// file: tb/bms_operator.sv
`timescale 1ns/100ps

// operator at the recessed button; contacts chatter before they settle
module bms_operator (
  input wire logic clk_i,
  input wire logic want_press_i,
  output logic button_n_o
);
  logic [1:0] chatter = 2'h0;
  logic last = 1'b0;
  logic want = 1'b0;
  initial button_n_o = 1'b1;
  always @(posedge clk_i) begin
    // taken at the edge; the bench moves the request just after it
    want = want_press_i;
    #5;
    if (want != last) begin
      last = want;
      chatter = 2'h3;
    end
    if (chatter != 2'h0) begin
      // bounce shorter than the debounce span, must be filtered out
      chatter = chatter - 2'h1;
      button_n_o = ~button_n_o;
    end else begin
      button_n_o = ~last;
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps

module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic activity = 1'b0;
  logic factory_done = 1'b0;
  logic want_press = 1'b0;
  logic ce = 1'b1;
  logic green_seen = 1'b0;
  logic button_n;
  logic amber, green, red, restart, restore, abandon, mode_active;
  logic [2:0] ev_prev = 3'h0;
  logic [2:0] ev_new;
  logic [2:0] expq[$];
  logic [2:0] colour [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
  int mismatches = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  bms_operator bms_operator_i (.clk_i(clk), .want_press_i(want_press), .button_n_o(button_n));

  // short counts keep the run brief: dwell 20, timeout 200, debounce 4, flash 3, restart 5
  localparam logic [31:0] T_DWELL = 32'h14;
  localparam logic [35:0] T_IDLE = 36'hC8;
  localparam logic [31:0] T_DEBOUNCE = 32'h4;
  localparam logic [31:0] T_FLASH = 32'h3;
  localparam logic [31:0] T_RESTART = 32'h5;

  bms_top #(.DWELL_CYC(T_DWELL), .IDLE_TO_CYC(T_IDLE), .DEBOUNCE_CYC(T_DEBOUNCE), .FLASH_CYC(T_FLASH),
    .RESTART_CYC(T_RESTART)) bms_top_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .BUTTON_N_I(button_n), .ACTIVITY_I(activity), .FACTORY_DONE_I(factory_done),
    .LED_AMBER_O(amber), .LED_GREEN_O(green), .LED_RED_O(red), .RESTART_O(restart),
    .FACTORY_RESTORE_O(restore), .ABANDON_O(abandon), .MODE_ACTIVE_O(mode_active));

  task automatic check3(input string what, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watcher: every commit result is matched against the oldest note
  always @(posedge clk) begin
    ev_new = {abandon, restore, restart} & ~ev_prev;
    if (ev_new != 3'h0) begin
      if (expq.size() == 0) begin
        check3("unexpected action", 3'h0, ev_new);
      end else begin
        check3("action", expq.pop_front(), ev_new);
      end
    end
    // indicator trails the state by a cycle, so red may still show on the first restart cycle
    if (restart === 1'b1) check3("restart indicator", 3'h0, {amber, 1'b0, red & ev_prev[0]});
    if (restart === 1'b1) green_seen = green_seen | green;
    if (restart !== 1'b1 && ev_prev[0]) begin
      check3("restart green", 3'h1, {2'h0, green_seen});
      green_seen = 1'b0;
    end
    if (restore === 1'b1) check3("restore indicator", 3'h0, {amber, green, 1'b0});
    if (abandon === 1'b1) check3("cancel indicator", 3'h0, {amber, green, red});
    ev_prev = {abandon, restore, restart};
  end

  // hold for mode k measured from base b; state time trails the loop index by about ten cycles
  task automatic hold(input int b, input int k, input bit act, input bit lock);
    logic [2:0] lit;
    int h;
    lit = 3'h0;
    h = b + 16 + $urandom % 3;
    want_press = 1'b1;
    for (int i = 0; i < h; i++) begin
      @(posedge clk);
      #5;
      activity = act && (i % 50 == 25);
      // first flash period after mode entry, always lit for a lit mode
      if (i >= b + 10 && i < b + 16) lit = lit | {amber, green, red};
    end
    activity = 1'b0;
    check3("mode colour", lock ? 3'h0 : colour[k % 4], lit);
    if (lock) check3("lockout", 3'h0, {2'h0, mode_active});
    if (!lock) check3("mode active", 3'h1, {2'h0, mode_active});
    if (!lock && k % 4 == 1) expq.push_back(3'h1);
    if (!lock && k % 4 == 2) begin
      expq.push_back(3'h2);
      expq.push_back(3'h1);
    end
    if (!lock && k % 4 == 3) expq.push_back(3'h4);
    want_press = 1'b0;
    if (!lock && k % 4 == 2) begin
      for (int j = 0; j < 40 && restore !== 1'b1; j++) @(posedge clk);
      repeat (6) @(posedge clk);
      #5;
      factory_done = 1'b1;
      @(posedge clk);
      #5;
      factory_done = 1'b0;
    end
    repeat (40) @(posedge clk);
    #5;
  endtask

  initial begin
    void'($urandom(52804));
    repeat (20) @(posedge clk);
    #5;
    rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #5;
    // enable low freezes debouncer and mode machine, so this press goes unseen
    ce = 1'b0;
    want_press = 1'b1;
    repeat (30) @(posedge clk);
    #5;
    check3("frozen outputs", 3'h0, {amber, green, mode_active});
    want_press = 1'b0;
    repeat (10) @(posedge clk);
    #5;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    #5;
    for (int k = 0; k < 4; k++) hold(20 * k, k, 1'b0, 1'b0);
    hold(120, 6, 1'b0, 1'b0);
    hold(260, 13, 1'b1, 1'b0);
    hold(260, 13, 1'b0, 1'b1);
    check3("pending actions", 3'h0, 3'(expq.size()));
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
